// File: rtl/port_e_pin_function_select.sv
// Contract
// R1: Two 16-bit read/write select registers, upper for pins 15-8, lower for 7-0.
// R2: Both clear on power-on reset; kept through watchdog reset, standby and sleep.
// R3: Single-chip mode turns bus and DMA selections back into general port pins.
// R4: Upper bits 15:14 pick pin 15: 00 port, 10 DMA ch1 acknowledge.
// R5: Upper bits 13:12 pick pin 14: 00 port, 10 DMA ch0 ack, 11 address hold.
// R6: Upper bits 11:0 read zero; software writes zeros there.
// R7: Lower odd bits 15,13,11,9 read zero; software writes zeros there.
// R8: Lower bits 14,12,10,8 route pins 7-4 to timer channels when set.
// R9: Lower bits 7:6 pick pin 3: port, timer, or DMA ch1 accepted.
// R10: Lower bits 5:4 pick pin 2: port, timer, or DMA ch1 request input.
// R11: Lower bits 3:2 pick pin 1: port, timer, or DMA ch0 accepted.
// R12: Lower bits 1:0 pick pin 0: port, timer, or DMA ch0 request input.
// R13: Direction bit sets output or input for port and timer functions only.
// R14: Reserved codes are illegal for software; pin function then undefined.
//
// Design decisions made here: the APB register port and the address map.
module port_e_pin_function_select (
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Power-on reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic single_chip, // Single-chip operating mode
  input wire logic [15:0] gpio_out, // Port data register bits
  output logic [15:0] gpio_in, // Pad levels to port data read
  input wire logic [7:0] timer_out, // Timer outputs for pins 7-0
  input wire logic [7:0] timer_oe, // Timer output enables
  output logic [7:0] timer_in, // Capture inputs for pins 7-0
  input wire logic dma_ch1_ack_out, // DMA ch1 acknowledge
  input wire logic dma_ch0_ack_out, // DMA ch0 acknowledge
  input wire logic addr_hold_out, // Bus address hold strobe
  input wire logic dma_ch1_accepted_out, // DMA ch1 request accepted
  input wire logic dma_ch0_accepted_out, // DMA ch0 request accepted
  output logic dma_ch1_request_in, // DMA ch1 request from pin 2
  output logic dma_ch0_request_in, // DMA ch0 request from pin 0
  input wire logic [15:0] pad_in, // Pad input levels
  output logic [15:0] pad_out, // Pad output values
  output logic [15:0] pad_oe // Pad output enables
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [15:0] upper_function_select_q;
  logic [15:0] upper_function_select_d;
  logic [15:0] lower_function_select_q;
  logic [15:0] lower_function_select_d;
  logic [15:0] port_e_direction_q;
  logic [15:0] port_e_direction_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pslverr_q;
  logic pslverr_d;

  pin_mux_pkg::pin_fn_t fn [16];
  logic [15:0] periph_out;
  logic [15:0] periph_is_out;

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Merge write data into a register, honouring strobes and the writable mask
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb, input logic [15:0] mask);
    logic [15:0] lanes;
    lanes = {{8{strb[1]}}, {8{strb[0]}}} & mask;
    merge = (old & ~lanes) | (wd[15:0] & lanes);
  endfunction

  // Resolve a two-bit code; code_dma/addr_hold only legal where allowed
  function automatic pin_mux_pkg::pin_fn_t resolve(input logic [1:0] code,
                                                   input logic timer_ok,
                                                   input logic dma_ok,
                                                   input logic hold_ok,
                                                   input logic sc);
    case (code)
      pin_mux_pkg::code_gpio: resolve = pin_mux_pkg::fn_gpio;
      pin_mux_pkg::code_timer:
        resolve = timer_ok ? pin_mux_pkg::fn_timer : pin_mux_pkg::fn_reserved;
      pin_mux_pkg::code_dma:
        resolve = !dma_ok ? pin_mux_pkg::fn_reserved
                : (sc ? pin_mux_pkg::fn_gpio : pin_mux_pkg::fn_periph); // [R3]
      pin_mux_pkg::code_addr_hold:
        resolve = !hold_ok ? pin_mux_pkg::fn_reserved
                : (sc ? pin_mux_pkg::fn_gpio : pin_mux_pkg::fn_periph); // [R3]
      default: resolve = pin_mux_pkg::fn_reserved;
    endcase
  endfunction

  // One-bit field: set routes the pin to its timer channel
  function automatic pin_mux_pkg::pin_fn_t timer_fn(input logic sel);
    timer_fn = sel ? pin_mux_pkg::fn_timer : pin_mux_pkg::fn_gpio;
  endfunction

  // ****************************************************************
  // APB slave
  // ****************************************************************
  logic access;
  logic addr_ok;

  assign access = psel & penable;
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  always_comb
  begin
    addr_ok = (paddr == pin_mux_pkg::upper_sel_addr) || (paddr == pin_mux_pkg::lower_sel_addr)
           || (paddr == pin_mux_pkg::direction_addr) || (paddr == pin_mux_pkg::mode_addr);
    upper_function_select_d = upper_function_select_q;
    lower_function_select_d = lower_function_select_q;
    port_e_direction_d = port_e_direction_q;
    prdata_d = prdata_q;
    // Judged in setup so the error stands for exactly the access cycle
    pslverr_d = psel & ~penable & ~addr_ok;
    if (psel & ~penable)
    begin
      // Read data is captured in setup so it stands through the access phase
      prdata_d = 32'h0000_0000;
      case (paddr)
        pin_mux_pkg::upper_sel_addr:
          prdata_d = {16'h0000, upper_function_select_q & pin_mux_pkg::upper_write_mask}; // [R6]
        pin_mux_pkg::lower_sel_addr:
          prdata_d = {16'h0000, lower_function_select_q & pin_mux_pkg::lower_write_mask}; // [R7]
        pin_mux_pkg::direction_addr: prdata_d = {16'h0000, port_e_direction_q};
        pin_mux_pkg::mode_addr: prdata_d = {31'h0000_0000, single_chip};
        default: prdata_d = 32'h0000_0000;
      endcase
    end
    if (access)
    begin
      if (pwrite)
      begin
        case (paddr)
          pin_mux_pkg::upper_sel_addr:
            upper_function_select_d = merge(upper_function_select_q, pwdata, pstrb,
                                            pin_mux_pkg::upper_write_mask); // [R1] [R6]
          pin_mux_pkg::lower_sel_addr:
            lower_function_select_d = merge(lower_function_select_q, pwdata, pstrb,
                                            pin_mux_pkg::lower_write_mask); // [R1] [R7]
          pin_mux_pkg::direction_addr:
            port_e_direction_d = merge(port_e_direction_q, pwdata, pstrb, 16'hFFFF);
          default: port_e_direction_d = port_e_direction_q;
        endcase
      end
    end
  end

  // Only the power-on reset reaches these flops; watchdog, standby and sleep
  // never touch presetn, so the selections survive them.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      upper_function_select_q <= pin_mux_pkg::sel_reset; // [R2]
      lower_function_select_q <= pin_mux_pkg::sel_reset; // [R2]
      port_e_direction_q <= pin_mux_pkg::direction_reset;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      upper_function_select_q <= upper_function_select_d;
      lower_function_select_q <= lower_function_select_d;
      port_e_direction_q <= port_e_direction_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ****************************************************************
  // Function decode
  // ****************************************************************
  logic [1:0] pin15_sel;
  logic [1:0] pin14_sel;
  logic [1:0] pin3_sel;
  logic [1:0] pin2_sel;
  logic [1:0] pin1_sel;
  logic [1:0] pin0_sel;
  logic pin7_sel;
  logic pin6_sel;
  logic pin5_sel;
  logic pin4_sel;

  assign pin15_sel = upper_function_select_q[pin_mux_pkg::pin15_sel_pos +: 2];
  assign pin14_sel = upper_function_select_q[pin_mux_pkg::pin14_sel_pos +: 2];
  assign pin3_sel = lower_function_select_q[pin_mux_pkg::pin3_sel_pos +: 2];
  assign pin2_sel = lower_function_select_q[pin_mux_pkg::pin2_sel_pos +: 2];
  assign pin1_sel = lower_function_select_q[pin_mux_pkg::pin1_sel_pos +: 2];
  assign pin0_sel = lower_function_select_q[pin_mux_pkg::pin0_sel_pos +: 2];
  assign pin7_sel = lower_function_select_q[pin_mux_pkg::pin7_sel_pos];
  assign pin6_sel = lower_function_select_q[pin_mux_pkg::pin6_sel_pos];
  assign pin5_sel = lower_function_select_q[pin_mux_pkg::pin5_sel_pos];
  assign pin4_sel = lower_function_select_q[pin_mux_pkg::pin4_sel_pos];

  always_comb
  begin
    for (int i = 8; i < 14; i++)
    begin
      fn[i] = pin_mux_pkg::fn_gpio;
    end
    fn[15] = resolve(pin15_sel, 1'b0, 1'b1, 1'b0, single_chip); // [R4]
    fn[14] = resolve(pin14_sel, 1'b0, 1'b1, 1'b1, single_chip); // [R5]
    fn[7] = timer_fn(pin7_sel); // [R8]
    fn[6] = timer_fn(pin6_sel); // [R8]
    fn[5] = timer_fn(pin5_sel); // [R8]
    fn[4] = timer_fn(pin4_sel); // [R8]
    fn[3] = resolve(pin3_sel, 1'b1, 1'b1, 1'b0, single_chip); // [R9]
    fn[2] = resolve(pin2_sel, 1'b1, 1'b1, 1'b0, single_chip); // [R10]
    fn[1] = resolve(pin1_sel, 1'b1, 1'b1, 1'b0, single_chip); // [R11]
    fn[0] = resolve(pin0_sel, 1'b1, 1'b1, 1'b0, single_chip); // [R12]
  end

  // ****************************************************************
  // Peripheral routing
  // ****************************************************************
  // Peripheral output values; pins 2 and 0 are inputs for the DMA requests
  always_comb
  begin
    periph_out = 16'h0000;
    periph_is_out = 16'h0000;
    periph_out[15] = dma_ch1_ack_out; // [R4]
    periph_is_out[15] = 1'b1;
    periph_out[14] = (pin14_sel == pin_mux_pkg::code_addr_hold)
                   ? addr_hold_out : dma_ch0_ack_out; // [R5]
    periph_is_out[14] = 1'b1;
    periph_out[3] = dma_ch1_accepted_out; // [R9]
    periph_is_out[3] = 1'b1;
    periph_out[1] = dma_ch0_accepted_out; // [R11]
    periph_is_out[1] = 1'b1;
  end

  // ****************************************************************
  // Pad cells
  // ****************************************************************
  for (genvar p = 0; p < 16; p++)
  begin : g_pin
    pin_cell u_cell (
      .gpio_out(gpio_out[p]),
      .dir(port_e_direction_q[p]),
      .timer_out(p < 8 ? timer_out[p % 8] : 1'b0),
      .timer_oe(p < 8 ? timer_oe[p % 8] : 1'b0),
      .periph_out(periph_out[p]),
      .periph_is_out(periph_is_out[p]),
      .fn(fn[p]),
      .pad_out(pad_out[p]),
      .pad_oe(pad_oe[p])
    );
  end

  // ****************************************************************
  // Pin inputs
  // ****************************************************************
  // Timer and DMA request inputs are gated so an unselected function sees a quiet zero; gpio_in follows pad_in ungated
  always_comb
  begin
    gpio_in = pad_in;
    for (int i = 0; i < 8; i++)
    begin
      timer_in[i] = (fn[i] == pin_mux_pkg::fn_timer) & ~port_e_direction_q[i]
                  & pad_in[i]; // [R13]
    end
    dma_ch1_request_in = (fn[2] == pin_mux_pkg::fn_periph) & pad_in[2]; // [R10]
    dma_ch0_request_in = (fn[0] == pin_mux_pkg::fn_periph) & pad_in[0]; // [R12]
  end

  logic unused_ok;
  assign unused_ok = (|pwdata[31:16]) | (|pstrb[3:2]);

endmodule

// File: rtl/pin_mux_pkg.sv
package pin_mux_pkg;

  // ****************************************************************
  // Register map (byte addresses, one aligned word each)
  // ****************************************************************
  localparam logic [11:0] upper_sel_addr = 12'h000;
  localparam logic [11:0] lower_sel_addr = 12'h004;
  localparam logic [11:0] direction_addr = 12'h008;
  localparam logic [11:0] mode_addr = 12'h00C;

  // ****************************************************************
  // Reset values and writable masks
  // ****************************************************************
  localparam logic [15:0] sel_reset = 16'h0000;
  localparam logic [15:0] direction_reset = 16'h0000;
  localparam logic [15:0] upper_write_mask = 16'hF000;
  localparam logic [15:0] lower_write_mask = 16'h55FF;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int pin15_sel_pos = 14;
  localparam int pin14_sel_pos = 12;
  localparam int pin7_sel_pos = 14;
  localparam int pin6_sel_pos = 12;
  localparam int pin5_sel_pos = 10;
  localparam int pin4_sel_pos = 8;
  localparam int pin3_sel_pos = 6;
  localparam int pin2_sel_pos = 4;
  localparam int pin1_sel_pos = 2;
  localparam int pin0_sel_pos = 0;

  // ****************************************************************
  // Function codes
  // ****************************************************************
  localparam logic [1:0] code_gpio = 2'h0;
  localparam logic [1:0] code_timer = 2'h1;
  localparam logic [1:0] code_dma = 2'h2;
  localparam logic [1:0] code_addr_hold = 2'h3;

  // Resolved function of a pin, one-hot
  typedef enum logic [3:0] {
    fn_gpio = 4'h1,
    fn_timer = 4'h2,
    fn_periph = 4'h4,
    fn_reserved = 4'h8
  } pin_fn_t;

endpackage

// File: rtl/pin_cell.sv
module pin_cell (
  input wire logic gpio_out, // Port data bit
  input wire logic dir, // Direction bit, 1 is output
  input wire logic timer_out, // Timer compare output
  input wire logic timer_oe, // Timer drives the pin
  input wire logic periph_out, // Bus or DMA output value
  input wire logic periph_is_out, // Peripheral function is an output
  input wire pin_mux_pkg::pin_fn_t fn, // Resolved function
  output logic pad_out, // Pad output value
  output logic pad_oe // Pad output enable
);

  always_comb
  begin
    pad_out = 1'b0;
    pad_oe = 1'b0;
    case (fn)
      pin_mux_pkg::fn_gpio:
      begin
        pad_out = gpio_out;
        pad_oe = dir; // [R13]
      end
      pin_mux_pkg::fn_timer:
      begin
        pad_out = timer_out;
        pad_oe = dir & timer_oe; // [R13]
      end
      pin_mux_pkg::fn_periph:
      begin
        pad_out = periph_out;
        pad_oe = periph_is_out;
      end
      default:
      begin
        // Reserved codes leave the pad undriven
        pad_out = 1'b0;
        pad_oe = 1'b0;
      end
    endcase
  end

endmodule

// File: testbench/pin_mux_props.sv
// ****************************************
// Port checks for the port E pin mux
// ****************************************
module pin_mux_props (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Write
  input wire logic [11:0] paddr, // Address
  input wire logic [31:0] pwdata, // Wdata
  input wire logic [3:0] pstrb, // Lanes
  input wire logic [31:0] prdata, // Rdata
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic single_chip, // Mode
  input wire logic [15:0] gpio_out, // Port data
  input wire logic [7:0] timer_in, // Capture
  input wire logic dma_ch1_request_in, // Req 1
  input wire logic dma_ch0_request_in, // Req 0
  input wire logic [15:0] pad_in, // Pads in
  input wire logic [15:0] pad_out, // Pads out
  input wire logic [15:0] pad_oe // Enables
);
  logic [15:0] lower_q;
  logic [15:0] lower_d;
  logic [15:0] lane_m;
  logic acc;
  logic mapped;
  assign acc = psel && penable;
  assign mapped = (paddr <= pin_mux_pkg::mode_addr) && (paddr[1:0] == 2'h0);
  assign lane_m = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  // Shadow of the lower select so read data is judged without peeking inside
  always_comb
  begin
    lower_d = lower_q;
    if (acc && pwrite && paddr == pin_mux_pkg::lower_sel_addr)
      lower_d = (lower_q & ~lane_m) | (pwdata[15:0] & lane_m & pin_mux_pkg::lower_write_mask);
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lower_q <= pin_mux_pkg::sel_reset;
    else
      lower_q <= lower_d;
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_zero_wait: assert property (acc |-> pready)
    else $error("pready low in access cycle");
  chk_unmapped_err: assert property (acc |-> pslverr == !mapped)
    else $error("pslverr wrong for address");
  chk_err_in_access: assert property (pslverr |-> acc)
    else $error("pslverr outside access cycle");
  chk_upper_ro_zero: assert property (
    acc && paddr == pin_mux_pkg::upper_sel_addr |-> prdata[11:0] == 12'h000
    && prdata[31:16] == 16'h0000) else $error("upper read-only bits not zero");
  chk_lower_readback: assert property (
    acc && !pwrite && paddr == pin_mux_pkg::lower_sel_addr |-> prdata == {16'h0000, lower_q})
    else $error("lower select read data wrong");
  chk_req0_source: assert property (
    dma_ch0_request_in |-> pad_in[0] && !pad_oe[0] && !single_chip)
    else $error("request 0 without its pin");
  chk_req1_source: assert property (
    dma_ch1_request_in |-> pad_in[2] && !pad_oe[2] && !single_chip)
    else $error("request 1 without its pin");
  chk_capture_input: assert property (
    timer_in != 8'h00 |-> (timer_in & ~(pad_in[7:0] & ~pad_oe[7:0])) == 8'h00)
    else $error("capture input from a driven or low pin");
  chk_fixed_pins: assert property (
    pad_oe[13:8] != 6'h00 |-> ((pad_out[13:8] ^ gpio_out[13:8]) & pad_oe[13:8]) == 6'h00)
    else $error("pins 13 to 8 not port pins");
  chk_single_chip_port: assert property (
    single_chip |-> ((pad_out[15:14] ^ gpio_out[15:14]) & pad_oe[15:14]) == 2'h0)
    else $error("pin 15 or 14 kept peripheral in single-chip mode");
  chk_reset_pads: assert property ($rose(presetn) |-> (pad_oe == 16'h0000) [*2])
    else $error("pads driven after reset");
endmodule

// File: testbench/periph_model.sv
// Timer, DMA and bus controller outputs; patterns move every cycle
module periph_model (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic dma_ch1_request_in, // Req 1
  input wire logic dma_ch0_request_in, // Req 0
  output logic [7:0] timer_out, // Compare out
  output logic [7:0] timer_oe, // Timer drives
  output logic dma_ch1_ack_out, // Ack 1
  output logic dma_ch0_ack_out, // Ack 0
  output logic addr_hold_out, // Hold strobe
  output logic dma_ch1_accepted_out, // Accepted 1
  output logic dma_ch0_accepted_out // Accepted 0
);
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [1:0] req_q;
  always_comb
    cnt_d = cnt_q + 16'h9E37;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= 16'h0000;
    else
      cnt_q <= cnt_d;
  end
  // A request seen on one edge is accepted on the next
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      req_q <= 2'h0;
    else
      req_q <= {dma_ch1_request_in, dma_ch0_request_in};
  end
  assign timer_out = cnt_q[7:0];
  assign timer_oe = cnt_q[15:8];
  assign {dma_ch1_ack_out, dma_ch0_ack_out, addr_hold_out} = cnt_q[11:9];
  assign dma_ch1_accepted_out = req_q[1] ^ cnt_q[4];
  assign dma_ch0_accepted_out = req_q[0] ^ cnt_q[6];
endmodule

// File: testbench/port_e_pin_function_select_tb_top.sv
module port_e_pin_function_select_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic single_chip = 1'b0, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata;
  logic [3:0] pstrb = 4'h0;
  logic [15:0] gpio_out = 16'h0000, pad_in = 16'h0000, gpio_in, pad_out, pad_oe;
  logic [7:0] timer_out, timer_oe, timer_in;
  logic dma_ch1_ack_out, dma_ch0_ack_out, addr_hold_out, dma_ch1_accepted_out;
  logic dma_ch0_accepted_out, dma_ch1_request_in, dma_ch0_request_in;
  logic [15:0] up_m = 16'h0000, lo_m = 16'h0000, dir_m = 16'h0000, rnd = 16'h0054;
  logic [15:0] utab [3] = '{16'h0000, 16'hA000, 16'h3000};
  int num_errors = 0, n_tests = 0;
  always #20 pclk = ~pclk;
  port_e_pin_function_select dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .single_chip, .gpio_out, .gpio_in, .timer_out,
    .timer_oe, .timer_in, .dma_ch1_ack_out, .dma_ch0_ack_out, .addr_hold_out,
    .dma_ch1_accepted_out, .dma_ch0_accepted_out, .dma_ch1_request_in, .dma_ch0_request_in,
    .pad_in, .pad_out, .pad_oe);
  periph_model far (.pclk, .presetn, .dma_ch1_request_in, .dma_ch0_request_in, .timer_out,
    .timer_oe, .dma_ch1_ack_out, .dma_ch0_ack_out, .addr_hold_out, .dma_ch1_accepted_out,
    .dma_ch0_accepted_out);
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // ****************************************
  // APB master and register model
  // ****************************************
  task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s);
    logic [31:0] rd;
    logic er;
    logic [15:0] m;
    m = {{8{s[1]}}, {8{s[0]}}} & d[15:0];
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // The answer is taken at the rising edge where pready is seen high
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    m = {{8{s[1]}}, {8{s[0]}}};
    if (wr && a == pin_mux_pkg::upper_sel_addr)
      up_m = (up_m & ~m) | (d[15:0] & m & 16'hF000);
    if (wr && a == pin_mux_pkg::lower_sel_addr)
      lo_m = (lo_m & ~m) | (d[15:0] & m & 16'h55FF);
    if (wr && a == pin_mux_pkg::direction_addr)
      dir_m = (dir_m & ~m) | (d[15:0] & m);
    m = (a == 12'h000) ? up_m : (a == 12'h004) ? lo_m : (a == 12'h008) ? dir_m :
      (a == 12'h00C) ? {15'h0000, single_chip} : 16'h0000;
    if (!wr)
      cmp("prdata", {16'h0000, m}, rd);
    cmp("pslverr", {31'h00000000, a > 12'h00C || a[1:0] != 2'h0}, {31'h00000000, er});
  endtask
  // ****************************************
  // Pin model
  // ****************************************
  task automatic check_pins();
    logic [15:0] eoe, eout, pv;
    logic [7:0] eti;
    logic [1:0] erq;
    int c, f;
    @(negedge pclk);
    eoe = 16'h0000;
    eout = 16'h0000;
    eti = 8'h00;
    erq = 2'h0;
    pv = {dma_ch1_ack_out, up_m[12] ? addr_hold_out : dma_ch0_ack_out, 10'h000,
      dma_ch1_accepted_out, 1'b0, dma_ch0_accepted_out, 1'b0};
    for (int p = 0; p < 16; p++)
    begin
      c = (p == 15) ? up_m[15:14] : (p == 14) ? up_m[13:12] : (p < 8) ? lo_m[2 * p +: 2] : 0;
      // 0 port, 1 timer, 2 peripheral output, 3 request input, 4 reserved
      f = (c == 0) ? 0 : (p < 8 && c == 1) ? 1 : (c == 2 && (p == 0 || p == 2)) ? 3 : 4;
      if ((c == 2 && p inside {15, 14, 3, 1}) || (c == 3 && p == 14))
        f = 2;
      if (single_chip && (f == 2 || f == 3))
        f = 0;
      eoe[p] = (f == 0) ? dir_m[p] : (f == 1) ? dir_m[p] & timer_oe[p % 8] : (f == 2);
      eout[p] = (f == 0) ? gpio_out[p] : (f == 1) ? timer_out[p % 8] : pv[p];
      if (f == 1 && !dir_m[p])
        eti[p % 8] = pad_in[p];
      if (f == 3)
        erq[p / 2] = pad_in[p];
    end
    cmp("pad_oe", eoe, pad_oe);
    cmp("pad_out", eout & eoe, pad_out & eoe);
    cmp("timer_in", eti, timer_in);
    cmp("dma_request", erq, {dma_ch1_request_in, dma_ch0_request_in});
    cmp("gpio_in", pad_in, gpio_in);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    close_out();
  end
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++)
      acc(1'b0, 12'(4 * i), 32'h00000000, 4'h0);
    check_pins();
    $display("test reset_values done");
    acc(1'b1, 12'h000, 32'hFFFFAFFF, 4'hF);
    acc(1'b1, 12'h004, 32'h0000FFAA, 4'hF);
    acc(1'b1, 12'h004, 32'h00000000, 4'h1);
    for (int i = 0; i < 2; i++)
      acc(1'b0, 12'(4 * i), 32'h00000000, 4'h0);
    $display("test read_only_bits done");
    // Every legal code of every field, both modes, random pads and directions
    for (int n = 0; n < 18; n++)
    begin
      @(posedge pclk);
      single_chip <= n[0];
      rnd = lfsr(rnd);
      acc(1'b1, 12'h000, {16'h0000, utab[n / 6]}, 4'h3);
      acc(1'b1, 12'h004, 32'((n / 2) % 3) * 32'h00005555, 4'h3);
      acc(1'b1, 12'h008, {16'h0000, rnd}, 4'h3);
      acc(1'b0, 12'h00C, 32'h00000000, 4'h0);
      repeat (3)
      begin
        @(posedge pclk);
        rnd = lfsr(rnd);
        gpio_out <= rnd;
        pad_in <= lfsr(rnd);
        check_pins();
      end
    end
    $display("test function_codes done");
    acc(1'b1, 12'h010, 32'hFFFFFFFF, 4'hF);
    acc(1'b0, 12'h010, 32'h00000000, 4'h0);
    acc(1'b0, 12'h004, 32'h00000000, 4'h0);
    $display("test unmapped done");
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    {up_m, lo_m, dir_m} = 48'h000000000000;
    for (int i = 0; i < 3; i++)
      acc(1'b0, 12'(4 * i), 32'h00000000, 4'h0);
    check_pins();
    $display("test second_reset done");
    close_out();
  end
endmodule
bind port_e_pin_function_select pin_mux_props props (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .single_chip, .gpio_out, .timer_in,
  .dma_ch1_request_in, .dma_ch0_request_in, .pad_in, .pad_out, .pad_oe);
